// ---- shared/domain_control_reg_pkg.sv ----
// Constants for the backup domain clock and power controller.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package domain_control_reg_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PRESCALE = 8'h04;
    localparam logic [7:0] OFF_RESET = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_INT_STAT = 8'h10;
    localparam logic [7:0] OFF_INT_CLR = 8'h14;
    localparam logic [7:0] OFF_INT_EN = 8'h18;
    localparam logic [7:0] OFF_ALARM0 = 8'h1c;
    localparam logic [7:0] OFF_ALARM1 = 8'h20;
    localparam logic [7:0] OFF_SECONDS = 8'h24;
    localparam logic [7:0] OFF_STORE = 8'h40;
    localparam logic [2:0] STORE_PAGE = 3'h2;
    // ==========================================================
    // Control, reset and alarm register fields
    localparam int CTRL_SUPPLY_LSB = 0;
    localparam int CTRL_CLK_SEL = 2;
    localparam int CTRL_OSC_EN = 3;
    localparam int CTRL_OSC_BYP = 4;
    localparam int CTRL_MEAS = 5;
    localparam int CTRL_KEY_LSB = 8;
    localparam logic [7:0] CHARGE_KEY = 8'h3c;
    localparam logic [1:0] SUPPLY_AUTO = 2'h0;
    localparam int RESET_BIT = 0;
    localparam int ALARM_EN_BIT = 31;
    // ==========================================================
    // Interrupt bits
    localparam int IRQ_TICK = 0;
    localparam int IRQ_ALARM0 = 1;
    localparam int IRQ_ALARM1 = 2;
    localparam int NIRQ = 3;
    // ==========================================================
    // Timing: backup clock rate and one-second division
    localparam int BACKUP_CLK_HZ = 32768;
    localparam int TICK_PERIOD_S = 1;
    localparam logic [16:0] DIV_RESET = 17'(BACKUP_CLK_HZ * TICK_PERIOD_S);
    localparam logic [16:0] DIV_MIN = 17'h00001;
    // ==========================================================
    // Pin input indices in the synchroniser bank
    localparam int PIN_OSC = 0;
    localparam int PIN_ALT = 1;
    localparam int PIN_BOD_EN = 2;
    localparam int PIN_BROWN = 3;
    localparam int PIN_MAIN_HI = 4;
    localparam int NPIN = 5;
    localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage

// ---- hw/backup_domain_ctl.sv ----
// Backup domain controller: supply select, charge key, domain reset,
// clock source select and divider, retained storage, alarms, interrupts.
// Assumes clk is the domain clock and rstn drops only on domain power loss.
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
module backup_domain_ctl #(
    parameter int DIV_W = 17,
    parameter int NWORDS = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic osc_clk_in,
    input wire logic alt_clk_in,
    input wire logic bod_enabled,
    input wire logic brownout,
    input wire logic main_higher,
    output logic use_backup_supply,
    output logic charge_enable,
    output logic oscillator_enable,
    output logic oscillator_bypass,
    output logic supply_measure_enable,
    output logic tick,
    output logic irq
);
    // ==========================================================
    // Elaboration checks
    if (DIV_W < 17 || DIV_W > 32) begin : g_bad_div
        $error("DIV_W must lie in 17..32");
    end
    if (NWORDS != 8) begin : g_bad_words
        $error("NWORDS must be 8");
    end

    // ==========================================================
    // Pin synchronisers
    localparam int NPIN_L = domain_control_reg_pkg::NPIN;
    logic [NPIN_L-1:0] pin_raw;
    logic [NPIN_L-1:0] pin_f_q;
    assign pin_raw = {main_higher, brownout, bod_enabled, alt_clk_in,
        osc_clk_in};
    for (genvar i = 0; i < NPIN_L; i++) begin : g_sync
        logic [2:0] s_q;
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                s_q <= domain_control_reg_pkg::SYNC_RESET;
                pin_f_q[i] <= 1'b0;
            end else begin
                s_q <= {s_q[1:0], pin_raw[i]};
                if (s_q[1] == s_q[2]) begin
                    pin_f_q[i] <= s_q[2];
                end
            end
        end
    end

    // ==========================================================
    // Bus handshake
    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_d;
    logic wr_acc;
    assign wr_acc = write && !wait_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else if ((read || write) && wait_q) begin
            wait_q <= 1'b0;
            rdata_q <= read ? rd_d : 32'h0;
        end else begin
            wait_q <= 1'b1;
        end
    end
    assign waitrequest = wait_q;
    assign readdata = rdata_q;

    function automatic logic wr_to(input logic [7:0] off);
        wr_to = wr_acc && address == off;
    endfunction

    // ==========================================================
    // Domain reset pulse
    logic soft_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= wr_to(domain_control_reg_pkg::OFF_RESET) &&
                writedata[domain_control_reg_pkg::RESET_BIT];
        end
    end

    // ==========================================================
    // Control register
    logic [1:0] supply_sel_q;
    logic clk_sel_q;
    logic osc_en_q;
    logic osc_byp_q;
    logic meas_q;
    logic [7:0] key_q;
    logic charge_q;
    // Only domain power loss or the soft pulse clears state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            supply_sel_q <= domain_control_reg_pkg::SUPPLY_AUTO;
            clk_sel_q <= 1'b0;
            osc_en_q <= 1'b0;
            osc_byp_q <= 1'b0;
            meas_q <= 1'b0;
            key_q <= 8'h0;
            charge_q <= 1'b0;
        end else if (soft_q) begin
            supply_sel_q <= domain_control_reg_pkg::SUPPLY_AUTO;
            clk_sel_q <= 1'b0;
            osc_en_q <= 1'b0;
            osc_byp_q <= 1'b0;
            meas_q <= 1'b0;
            key_q <= 8'h0;
            charge_q <= 1'b0;
        end else if (wr_to(domain_control_reg_pkg::OFF_CTRL)) begin
            supply_sel_q <= writedata[domain_control_reg_pkg::CTRL_SUPPLY_LSB +: 2];
            clk_sel_q <= writedata[domain_control_reg_pkg::CTRL_CLK_SEL];
            osc_en_q <= writedata[domain_control_reg_pkg::CTRL_OSC_EN];
            osc_byp_q <= writedata[domain_control_reg_pkg::CTRL_OSC_BYP];
            meas_q <= writedata[domain_control_reg_pkg::CTRL_MEAS];
            key_q <= writedata[domain_control_reg_pkg::CTRL_KEY_LSB +: 8];
            charge_q <= writedata[domain_control_reg_pkg::CTRL_KEY_LSB +: 8] ==
                domain_control_reg_pkg::CHARGE_KEY;
        end
    end
    assign charge_enable = charge_q;
    assign oscillator_enable = osc_en_q;
    assign oscillator_bypass = osc_byp_q;
    assign supply_measure_enable = meas_q;

    // ==========================================================
    // Supply selector
    logic backup_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            backup_q <= 1'b0;
        end else if (supply_sel_q != domain_control_reg_pkg::SUPPLY_AUTO) begin
            backup_q <= 1'b1;
        end else if (pin_f_q[domain_control_reg_pkg::PIN_BOD_EN] &&
            !pin_f_q[domain_control_reg_pkg::PIN_BROWN]) begin
            backup_q <= 1'b0;
        end else begin
            backup_q <= !pin_f_q[domain_control_reg_pkg::PIN_MAIN_HI];
        end
    end
    assign use_backup_supply = backup_q;

    // ==========================================================
    // Clock source and one-second divider
    logic src_q;
    logic src_d;
    logic src_rise;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] cnt_q;
    logic tick_q;
    logic [31:0] secs_q;
    assign src_d = clk_sel_q ? pin_f_q[domain_control_reg_pkg::PIN_ALT] :
        pin_f_q[domain_control_reg_pkg::PIN_OSC];
    assign src_rise = src_d && !src_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= DIV_W'(domain_control_reg_pkg::DIV_RESET);
        end else if (soft_q) begin
            div_q <= DIV_W'(domain_control_reg_pkg::DIV_RESET);
        end else if (wr_to(domain_control_reg_pkg::OFF_PRESCALE)) begin
            div_q <= (writedata[DIV_W-1:0] == '0) ?
                DIV_W'(domain_control_reg_pkg::DIV_MIN) : writedata[DIV_W-1:0];
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_q <= 1'b0;
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (soft_q) begin
            src_q <= 1'b0;
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            src_q <= src_d;
            tick_q <= 1'b0;
            if (src_rise) begin
                if (cnt_q >= div_q - DIV_W'(1)) begin
                    cnt_q <= '0;
                    tick_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + DIV_W'(1);
                end
            end
        end
    end
    assign tick = tick_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            secs_q <= 32'h0;
        end else if (soft_q) begin
            secs_q <= 32'h0;
        end else if (wr_to(domain_control_reg_pkg::OFF_SECONDS)) begin
            secs_q <= writedata;
        end else if (src_rise && cnt_q >= div_q - DIV_W'(1)) begin
            secs_q <= secs_q + 32'h1;
        end
    end

    // ==========================================================
    // Alarms
    logic [31:0] alarm_q [2];
    logic [1:0] alarm_hit;
    for (genvar a = 0; a < 2; a++) begin : g_alarm
        localparam logic [7:0] OFF = (a == 0) ?
            domain_control_reg_pkg::OFF_ALARM0 : domain_control_reg_pkg::OFF_ALARM1;
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                alarm_q[a] <= 32'h0;
            end else if (soft_q) begin
                alarm_q[a] <= 32'h0;
            end else if (wr_to(OFF)) begin
                alarm_q[a] <= writedata;
            end
        end
        assign alarm_hit[a] = tick_q &&
            alarm_q[a][domain_control_reg_pkg::ALARM_EN_BIT] &&
            secs_q[30:0] == alarm_q[a][30:0];
    end

    // ==========================================================
    // Interrupts
    localparam int NI = domain_control_reg_pkg::NIRQ;
    logic [NI-1:0] ist_q;
    logic [NI-1:0] ien_q;
    logic [NI-1:0] ev;
    logic [NI-1:0] clr;
    logic irq_q;
    assign ev = {alarm_hit, tick_q};
    assign clr = wr_to(domain_control_reg_pkg::OFF_INT_CLR) ? writedata[NI-1:0] :
        '0;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ist_q <= '0;
            ien_q <= '0;
        end else if (soft_q) begin
            ist_q <= '0;
            ien_q <= '0;
        end else begin
            ist_q <= (ist_q & ~clr) | ev;
            if (wr_to(domain_control_reg_pkg::OFF_INT_EN)) begin
                ien_q <= writedata[NI-1:0];
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ist_q & ien_q);
        end
    end
    assign irq = irq_q;

    // ==========================================================
    // Retained storage
    logic [31:0] store_q [NWORDS];
    logic st_sel;
    assign st_sel = address[7:5] == domain_control_reg_pkg::STORE_PAGE;
    for (genvar w = 0; w < NWORDS; w++) begin : g_store
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                store_q[w] <= 32'h0;
            end else if (soft_q) begin
                store_q[w] <= 32'h0;
            end else if (wr_acc && st_sel && address[4:2] == 3'(w)) begin
                for (int b = 0; b < 4; b++) begin
                    if (byteenable[b]) begin
                        store_q[w][8*b +: 8] <= writedata[8*b +: 8];
                    end
                end
            end
        end
    end

    // ==========================================================
    // Read mux
    always_comb begin
        rd_d = 32'h0;
        if (st_sel) begin
            rd_d = store_q[address[4:2]];
        end else begin
            unique case (address)
                domain_control_reg_pkg::OFF_CTRL: begin
                    rd_d = {16'h0, key_q, 2'h0, meas_q, osc_byp_q,
                        osc_en_q, clk_sel_q, supply_sel_q};
                end
                domain_control_reg_pkg::OFF_PRESCALE: rd_d = 32'(div_q);
                domain_control_reg_pkg::OFF_STATUS: begin
                    rd_d = {28'h0, charge_q, src_q,
                        pin_f_q[domain_control_reg_pkg::PIN_OSC], backup_q};
                end
                domain_control_reg_pkg::OFF_INT_STAT: rd_d = 32'(ist_q);
                domain_control_reg_pkg::OFF_INT_EN: rd_d = 32'(ien_q);
                domain_control_reg_pkg::OFF_ALARM0: rd_d = alarm_q[0];
                domain_control_reg_pkg::OFF_ALARM1: rd_d = alarm_q[1];
                domain_control_reg_pkg::OFF_SECONDS: rd_d = secs_q;
                default: rd_d = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_reset_write;
        wr_to(domain_control_reg_pkg::OFF_RESET) &&
            writedata[domain_control_reg_pkg::RESET_BIT];
    endsequence
    sequence s_domain_clear;
        soft_q ##1 (store_q[0] == 32'h0 && !charge_q && !osc_en_q);
    endsequence
    sequence s_req_wait;
        (read || write) && wait_q;
    endsequence

    property p_auto_main;
        supply_sel_q == domain_control_reg_pkg::SUPPLY_AUTO &&
            pin_f_q[domain_control_reg_pkg::PIN_BOD_EN] &&
            !pin_f_q[domain_control_reg_pkg::PIN_BROWN] |=> !backup_q;
    endproperty
    a_auto_main: assert property (p_auto_main)
        else $error("auto mode left main supply");

    property p_force_backup;
        supply_sel_q != domain_control_reg_pkg::SUPPLY_AUTO |=> backup_q;
    endproperty
    a_force_backup: assert property (p_force_backup)
        else $error("forced mode did not pick backup");

    property p_key_only;
        $rose(charge_q) |-> $past(wr_to(domain_control_reg_pkg::OFF_CTRL) &&
            writedata[domain_control_reg_pkg::CTRL_KEY_LSB +: 8] ==
            domain_control_reg_pkg::CHARGE_KEY);
    endproperty
    a_key_only: assert property (p_key_only)
        else $error("charging rose without key");

    property p_domain_reset;
        s_reset_write |=> s_domain_clear;
    endproperty
    a_domain_reset: assert property (p_domain_reset)
        else $error("domain reset did not clear state");

    property p_tick_cause;
        tick_q |-> $past(src_rise && cnt_q >= div_q - DIV_W'(1)) &&
            cnt_q == '0;
    endproperty
    a_tick_cause: assert property (p_tick_cause)
        else $error("tick without terminal count");

    property p_osc_enable;
        wr_to(domain_control_reg_pkg::OFF_CTRL) && !soft_q |=>
            osc_en_q == $past(writedata[domain_control_reg_pkg::CTRL_OSC_EN]);
    endproperty
    a_osc_enable: assert property (p_osc_enable)
        else $error("oscillator enable not taken");

    property p_store_hold;
        !(wr_acc && st_sel) && !soft_q |=> $stable(store_q[0]);
    endproperty
    a_store_hold: assert property (p_store_hold)
        else $error("storage changed without write");

    property p_irq_level;
        ##1 irq_q == |($past(ist_q) & $past(ien_q));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq does not follow enabled status");

    property p_bus_answer;
        s_req_wait |=> !wait_q ##1 wait_q;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not one cycle");
endmodule

// ---- testbench/backup_osc_model.sv ----
// Pin-side model: watch oscillator and alternate low-frequency clock.
// Assumes the oscillator pin toggles only while the enable output is high.
`timescale 1ns/10ps
module backup_osc_model #(
    parameter int OSC_HALF_NS = 40,
    parameter int ALT_HALF_NS = 60
) (
    input wire logic oscillator_enable,
    input wire logic oscillator_bypass,
    output logic osc_clk_in,
    output logic alt_clk_in
);
    // ==========================================================
    // Oscillator stands still while disabled
    initial begin
        osc_clk_in = 1'b0;
        #3;
        forever begin
            #OSC_HALF_NS;
            if (oscillator_enable === 1'b1) begin
                osc_clk_in = !osc_clk_in;
            end else begin
                osc_clk_in = 1'b0;
            end
        end
    end
    // ==========================================================
    // Alternate clock runs free, phase unrelated
    initial begin
        alt_clk_in = 1'b0;
        #7;
        forever begin
            #ALT_HALF_NS;
            alt_clk_in = !alt_clk_in;
        end
    end
endmodule

// ---- testbench/backup_domain_ctl_test.sv ----
// Self-checking bench for the backup domain controller.
// Assumes the Avalon slave answers by dropping waitrequest.
`timescale 1ns/10ps
module backup_domain_ctl_test;
    logic clk, rstn, read, write, bod_enabled, brownout, main_higher;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    logic waitrequest, osc_clk_in, alt_clk_in, use_backup_supply, tick, irq;
    logic charge_enable, oscillator_enable, oscillator_bypass;
    logic supply_measure_enable;
    int failures, checked, n;
    logic [5:0] sup_tab [8];
    logic [16:0] pre_tab [4];
    backup_domain_ctl backup_domain_ctl_i (.clk(clk), .rstn(rstn),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .osc_clk_in(osc_clk_in), .alt_clk_in(alt_clk_in),
        .bod_enabled(bod_enabled), .brownout(brownout),
        .main_higher(main_higher), .use_backup_supply(use_backup_supply),
        .charge_enable(charge_enable),
        .oscillator_enable(oscillator_enable),
        .oscillator_bypass(oscillator_bypass),
        .supply_measure_enable(supply_measure_enable),
        .tick(tick), .irq(irq));
    backup_osc_model backup_osc_model_i (
        .oscillator_enable(oscillator_enable),
        .oscillator_bypass(oscillator_bypass),
        .osc_clk_in(osc_clk_in), .alt_clk_in(alt_clk_in));
    // ==========================================================
    // Clock, watchdog, verdict
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    initial begin
        #300us;
        failures++;
        $display("watchdog expired");
        finish_test();
    end
    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // Bus access and comparison
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
        logic [3:0] be);
        int w;
        w = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            w++;
        end while (waitrequest !== 1'b0 && w < 100);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (w >= 100) chk("bus answer", 0, 1);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rdchk(string nm, logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(nm, e, rd);
    endtask
    task automatic count_ticks(int cycles);
        n = 0;
        repeat (cycles) begin
            @(negedge clk);
            if (tick === 1'b1) n++;
        end
    endtask
    task automatic tick_gap(int e);
        int g;
        g = 0;
        do @(negedge clk); while (tick !== 1'b1 && g++ < 2000);
        g = 0;
        do begin
            @(negedge clk);
            g++;
        end while (tick !== 1'b1 && g < 2000);
        chk("tick gap", e, g);
    endtask
    task automatic pins(logic [2:0] p);
        @(posedge clk);
        {bod_enabled, brownout, main_higher} <= p;
    endtask
    // ==========================================================
    // Test sequence
    initial begin
        {rstn, read, write, bod_enabled, brownout, main_higher} = 6'h0;
        address = 8'h0;
        writedata = 32'h0;
        byteenable = 4'hf;
        failures = 0;
        checked = 0;
        sup_tab = '{6'h08, 6'h0e, 6'h0d, 6'h02, 6'h01, 6'h19, 6'h2b, 6'h33};
        pre_tab = '{17'h08000, 17'h0003c, 17'h00032, 17'h00000};
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk("waitrequest idle", 1, waitrequest);
        rdchk("ctrl reset", domain_control_reg_pkg::OFF_CTRL, 0);
        rdchk("prescale reset", domain_control_reg_pkg::OFF_PRESCALE, 32'h8000);
        rdchk("int stat reset", domain_control_reg_pkg::OFF_INT_STAT, 0);
        rdchk("unmapped", 8'h80, 0);
        chk("irq reset", 0, irq);
        $display("test reset done");
        // Supply selector: {sel, bod, brown, main_higher, expected}
        foreach (sup_tab[i]) begin
            wr(domain_control_reg_pkg::OFF_CTRL, 32'(sup_tab[i][5:4]));
            pins(sup_tab[i][3:1]);
            repeat (12) @(posedge clk);
            chk("supply", 32'(sup_tab[i][0]), use_backup_supply);
        end
        $display("test supply done");
        wr(domain_control_reg_pkg::OFF_CTRL, 32'h3c20);
        repeat (2) @(posedge clk);
        chk("charge key", 1, charge_enable);
        chk("measure", 1, supply_measure_enable);
        rdchk("status", domain_control_reg_pkg::OFF_STATUS, 32'h8);
        wr(domain_control_reg_pkg::OFF_CTRL, 32'h3d00);
        repeat (2) @(posedge clk);
        chk("wrong key", 0, charge_enable);
        foreach (pre_tab[i]) begin
            wr(domain_control_reg_pkg::OFF_PRESCALE, 32'(pre_tab[i]));
            rdchk("prescale", domain_control_reg_pkg::OFF_PRESCALE,
                i == 3 ? 1 : 32'(pre_tab[i]));
        end
        $display("test charge and divider done");
        // Crystal start: bypass cleared first, then enable
        wr(domain_control_reg_pkg::OFF_CTRL, 32'h0);
        wr(domain_control_reg_pkg::OFF_PRESCALE, 2);
        wr(domain_control_reg_pkg::OFF_CTRL, 32'h8);
        repeat (2) @(posedge clk);
        chk("osc enable", 1, oscillator_enable);
        tick_gap(16);
        wr(domain_control_reg_pkg::OFF_CTRL, 32'hc);
        tick_gap(24);
        wr(domain_control_reg_pkg::OFF_CTRL, 32'h10);
        repeat (2) @(posedge clk);
        chk("bypass", 1, oscillator_bypass);
        chk("osc stopped", 0, oscillator_enable);
        count_ticks(200);
        chk("no ticks", 0, n);
        $display("test clocking done");
        wr(domain_control_reg_pkg::OFF_CTRL, 32'h8);
        wr(domain_control_reg_pkg::OFF_ALARM0, 32'h80000003);
        wr(domain_control_reg_pkg::OFF_ALARM1, 32'h80000005);
        wr(domain_control_reg_pkg::OFF_INT_EN, 32'h6);
        do @(negedge clk); while (tick !== 1'b1);
        wr(domain_control_reg_pkg::OFF_SECONDS, 0);
        count_ticks(8 * 16 - 6);
        chk("ticks counted", 7, n);
        rdchk("seconds", domain_control_reg_pkg::OFF_SECONDS, 32'(n));
        rdchk("alarms", domain_control_reg_pkg::OFF_INT_STAT, 32'h7);
        chk("irq alarm", 1, irq);
        wr(domain_control_reg_pkg::OFF_INT_CLR, 32'h6);
        repeat (3) @(posedge clk);
        chk("irq cleared", 0, irq);
        wr(domain_control_reg_pkg::OFF_INT_EN, 32'h1);
        count_ticks(40);
        chk("irq tick", 1, irq);
        wr(domain_control_reg_pkg::OFF_INT_EN, 32'h0);
        repeat (3) @(posedge clk);
        chk("irq masked", 0, irq);
        $display("test interrupts done");
        for (int i = 0; i < 8; i++) begin
            wr(domain_control_reg_pkg::OFF_STORE + 8'(4 * i), 32'h11111111 * i);
        end
        bus(1'b1, domain_control_reg_pkg::OFF_STORE, 32'haabbccdd, 4'h5);
        rdchk("store byte", domain_control_reg_pkg::OFF_STORE, 32'h00bb00dd);
        for (int i = 1; i < 8; i++) begin
            rdchk("store", domain_control_reg_pkg::OFF_STORE + 8'(4 * i),
                32'h11111111 * i);
        end
        $display("test storage done");
        wr(domain_control_reg_pkg::OFF_RESET, 32'h1);
        repeat (3) @(posedge clk);
        rdchk("store after reset", domain_control_reg_pkg::OFF_STORE + 8'h4, 0);
        rdchk("prescale after reset", domain_control_reg_pkg::OFF_PRESCALE,
            32'h8000);
        rdchk("ctrl after reset", domain_control_reg_pkg::OFF_CTRL, 0);
        chk("osc after reset", 0, oscillator_enable);
        $display("test domain reset done");
        finish_test();
    end
endmodule
